/* File: inc/visu_regs.vh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 8-bit i/o bus of the core, 40 MHz clock
// Notes: definitions only
`ifndef VISU_REGS_VH
`define VISU_REGS_VH

// ==========================================================
// i/o offsets
`define VISU_IO_EXT_FLAG 6'h3a
`define VISU_IO_TIMER_IRQ_MASK 6'h39
`define VISU_IO_STACK_POINTER 6'h3d
`define VISU_IO_STATUS_REG 6'h3f

// ==========================================================
// field positions
`define VISU_EXT0_FLAG_BIT 6
`define VISU_T1_OVF_EN_BIT 7
`define VISU_T1_CMP_EN_BIT 6
`define VISU_T1_CAP_EN_BIT 3
`define VISU_T0_OVF_EN_BIT 1
`define VISU_GLOBAL_EN_BIT 7
`define VISU_TIMER_IRQ_MASK_WMASK 8'hca
`define VISU_EXT_FLAG_RMASK 8'h40

// ==========================================================
// reset values
`define VISU_TIMER_IRQ_MASK_RESET 8'h00
`define VISU_SP_RESET 8'h00
`define VISU_STATUS_RESET 8'h00

// ==========================================================
// vectors and timing
`define VISU_NUM_VEC 14
`define VISU_VEC_RESET 12'h000
`define VISU_RST_MIN_NS 50
`define VISU_CLK_MHZ 40
`define VISU_TOUT_CYCLES 16384

`endif

/* File: rtl/visu_core.v */
// Purpose: vectored reset/interrupt unit with stack pointer for an 8-bit core
// Assumes: core sequencer gives one-cycle strobes; i/o bus on clk
// Notes: reset pin is asynchronous; core held until time-out expires
`timescale 1ns/1ps
`default_nettype none
`include "visu_regs.vh"
module visu_core #(
  parameter TOUT_CYCLES = `VISU_TOUT_CYCLES
) (
  // clock and resets
  input wire clk,
  input wire rst,
  input wire reset_pin_n,
  input wire por_event,
  input wire brownout_event,
  input wire watchdog_event,
  // external interrupt pins
  input wire ext_irq0,
  input wire ext_irq1,
  // ext_irq0 sense configuration: 1 = flag held clear, no request; else edge
  input wire ext0_level_mode,
  input wire ext0_rising,
  input wire ext1_enable,
  // peripheral requests, same clock, level flags
  input wire t1_cap_flag,
  input wire t1_cmp_flag,
  input wire t1_ovf_flag,
  input wire t0_ovf_flag,
  input wire spi_done,
  input wire rx_done,
  input wire tx_reg_empty,
  input wire tx_done,
  input wire adc_done,
  input wire nv_ready,
  input wire comparator_event,
  input wire [8:0] periph_enable,
  // core sequencer
  input wire instr_boundary,
  input wire [11:0] return_pc,
  input wire push_byte,
  input wire pop_byte,
  input wire call_push,
  input wire sub_return_instr,
  input wire irq_return_instr,
  // i/o bus of the core
  input wire [5:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  // to the core
  output reg core_reset,
  output reg pc_load,
  output reg [11:0] pc_vector,
  output reg push_ret,
  output reg [11:0] push_addr,
  output reg [7:0] stack_pointer,
  output reg global_en,
  output reg ext0_flag
);
  // ==========================================================
  // pin synchronisers
  wire rst_pin_s;
  wire irq0_s;
  wire irq1_s;

  visu_sync2 #(.INIT(1'b1)) u_sync_rst (
    .clk(clk),
    .rst(rst),
    .din(reset_pin_n),
    .dout(rst_pin_s)
  );
  visu_sync2 #(.INIT(1'b0)) u_sync_i0 (
    .clk(clk),
    .rst(rst),
    .din(ext_irq0),
    .dout(irq0_s)
  );
  visu_sync2 #(.INIT(1'b0)) u_sync_i1 (
    .clk(clk),
    .rst(rst),
    .din(ext_irq1),
    .dout(irq1_s)
  );

  // ==========================================================
  // reset and start-up delay
  localparam CW = 24;
  reg [CW-1:0] tout_cnt;
  reg irq0_prev;
  reg [7:0] timer_irq_mask;
  wire any_reset;
  wire pin_arst;

  // all reset kinds share one vector
  assign any_reset = ~rst_pin_s | por_event | brownout_event | watchdog_event;

  // pin low resets with no clock
  // release is safe: the synced copy keeps any_reset high two more edges
  assign pin_arst = rst | ~reset_pin_n;

  always @(posedge clk or posedge pin_arst) begin
    if (pin_arst) begin
      tout_cnt <= {CW{1'b0}};
      core_reset <= 1'b1;
    end else if (any_reset) begin
      tout_cnt <= {CW{1'b0}};
      core_reset <= 1'b1;
    end else if (core_reset) begin
      if (tout_cnt >= TOUT_CYCLES[CW-1:0] - 1'b1) begin
        core_reset <= 1'b0;
      end else begin
        tout_cnt <= tout_cnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // request gathering
  // thirteen sources, index 0 is vector 001
  wire [12:0] req;
  wire pick_any;
  wire [3:0] pick_idx;
  wire can_take;

  assign req[0] = ext0_flag & periph_enable[0];
  assign req[1] = irq1_s & ext1_enable;
  assign req[2] = t1_cap_flag & timer_irq_mask[`VISU_T1_CAP_EN_BIT];
  assign req[3] = t1_cmp_flag & timer_irq_mask[`VISU_T1_CMP_EN_BIT];
  assign req[4] = t1_ovf_flag & timer_irq_mask[`VISU_T1_OVF_EN_BIT];
  assign req[5] = t0_ovf_flag & timer_irq_mask[`VISU_T0_OVF_EN_BIT];
  assign req[6] = spi_done & periph_enable[1];
  assign req[7] = rx_done & periph_enable[2];
  assign req[8] = tx_reg_empty & periph_enable[3];
  assign req[9] = tx_done & periph_enable[4];
  assign req[10] = adc_done & periph_enable[5];
  assign req[11] = nv_ready & periph_enable[6];
  assign req[12] = comparator_event & periph_enable[7];

  visu_prio #(.N(13)) u_prio (
    .req(req),
    .any(pick_any),
    .idx(pick_idx)
  );

  assign can_take = global_en & pick_any & instr_boundary & ~core_reset & ~pc_load;

  // ==========================================================
  // ext0 flag
  wire ext0_edge;
  wire ext0_clr_wr;
  wire ext0_enter;

  assign ext0_edge = ext0_rising ? (irq0_s & ~irq0_prev) : (~irq0_s & irq0_prev);
  assign ext0_clr_wr = io_wr & (io_addr == `VISU_IO_EXT_FLAG) &
                       io_wdata[`VISU_EXT0_FLAG_BIT];
  assign ext0_enter = can_take & (pick_idx == 4'h0);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq0_prev <= 1'b0;
      ext0_flag <= 1'b0;
    end else begin
      irq0_prev <= irq0_s;
      if (ext0_level_mode) begin
        ext0_flag <= 1'b0;
      // edge sets flag, set beats clear
      end else if (ext0_edge) begin
        ext0_flag <= 1'b1;
      end else if (ext0_enter | ext0_clr_wr) begin
        ext0_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // vector entry, global enable, stack
  reg [7:0] next_sp;

  always @* begin
    next_sp = stack_pointer;
    if (can_take | call_push) begin
      next_sp = stack_pointer - 8'h02;
    end else if (sub_return_instr | irq_return_instr) begin
      next_sp = stack_pointer + 8'h02;
    end else if (push_byte) begin
      next_sp = stack_pointer - 8'h01;
    end else if (pop_byte) begin
      next_sp = stack_pointer + 8'h01;
    end
  end

  always @(posedge clk or posedge pin_arst) begin
    if (pin_arst) begin
      pc_load <= 1'b1;
      pc_vector <= `VISU_VEC_RESET;
      push_ret <= 1'b0;
      push_addr <= 12'h000;
      stack_pointer <= `VISU_SP_RESET;
      global_en <= 1'b0;
      timer_irq_mask <= `VISU_TIMER_IRQ_MASK_RESET;
    end else if (core_reset) begin
      // reset vector 000 held while in reset
      pc_load <= 1'b1;
      pc_vector <= `VISU_VEC_RESET;
      push_ret <= 1'b0;
      global_en <= 1'b0;
      timer_irq_mask <= `VISU_TIMER_IRQ_MASK_RESET;
    end else begin
      pc_load <= 1'b0;
      push_ret <= 1'b0;
      if (can_take) begin
        pc_load <= 1'b1;
        pc_vector <= {8'h00, pick_idx} + 12'h001;
        push_ret <= 1'b1;
        push_addr <= return_pc;
        global_en <= 1'b0;
      end else if (irq_return_instr) begin
        global_en <= 1'b1;
      end else if (io_wr & (io_addr == `VISU_IO_STATUS_REG)) begin
        global_en <= io_wdata[`VISU_GLOBAL_EN_BIT];
      end
      if (io_wr & (io_addr == `VISU_IO_STACK_POINTER)) begin
        stack_pointer <= io_wdata;
      end else begin
        stack_pointer <= next_sp;
      end
      if (io_wr & (io_addr == `VISU_IO_TIMER_IRQ_MASK)) begin
        timer_irq_mask <= io_wdata & `VISU_TIMER_IRQ_MASK_WMASK;
      end
    end
  end

  // ==========================================================
  // read port, registered
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        // flag at bit 6, rest zero
        `VISU_IO_EXT_FLAG: io_rdata <= {1'b0, ext0_flag, 6'h00};
        `VISU_IO_TIMER_IRQ_MASK: io_rdata <= timer_irq_mask;
        `VISU_IO_STACK_POINTER: io_rdata <= stack_pointer;
        `VISU_IO_STATUS_REG: io_rdata <= {global_en, 7'h00};
        default: io_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/visu_prio.v */
// Purpose: fixed-priority pick of the lowest-numbered pending vector
// Assumes: bit 0 of req is vector 1
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module visu_prio #(
  parameter N = 13
) (
  // request vector
  input wire [N-1:0] req,
  // result
  output reg any,
  output reg [3:0] idx
);
  integer i;

  always @* begin
    any = 1'b0;
    idx = 4'h0;
    // lowest index wins, so scan from the top down
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[3:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/visu_sync2.v */
// Purpose: two-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk
// Notes: reset value is a parameter constant
`timescale 1ns/1ps
`default_nettype none
module visu_sync2 #(
  parameter [0:0] INIT = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // level
  input wire din,
  output reg dout
);
  reg meta;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_vectored_interrupt_stack_unit.sv */
// Purpose: directed tests of the interrupt unit
// Assumes: short start-up delay of 8 cycles
// Notes: sequencer stand-in gives boundary and return address
`timescale 1ns/1ps
`default_nettype none
module test_vectored_interrupt_stack_unit;
  logic clk, rst, pin_n, wdog, irq0, lvl, e1en, slow, iwr, ird, iret_p, bnd, pl, pr, gie, flag;
  logic pret, rise;
  logic [8:0] pen;
  logic [11:0] paddr;
  logic [13:2] src;
  logic [3:0] seq;
  logic [5:0] ia;
  logic [7:0] iwd, rdat, sp;
  logic [11:0] rpc, vec;
  logic [7:0] sp_tab [4] = '{8'hcf, 8'hd0, 8'hce, 8'hd0};
  int miscompares = 0, check_count = 0, cycles = 0, k;
  visu_seq_model i_seq (.clk(clk), .slow(slow), .instr_boundary(bnd), .return_pc(rpc));
  visu_core #(.TOUT_CYCLES(8)) i_dut (.clk(clk), .rst(rst), .reset_pin_n(pin_n),
    .por_event(1'b0), .brownout_event(1'b0), .watchdog_event(wdog), .ext_irq0(irq0),
    .ext_irq1(src[2]), .ext0_level_mode(lvl), .ext0_rising(rise), .ext1_enable(e1en),
    .t1_cap_flag(src[3]), .t1_cmp_flag(src[4]), .t1_ovf_flag(src[5]), .t0_ovf_flag(src[6]),
    .spi_done(src[7]), .rx_done(src[8]), .tx_reg_empty(src[9]), .tx_done(src[10]),
    .adc_done(src[11]), .nv_ready(src[12]), .comparator_event(src[13]),
    .periph_enable(pen), .instr_boundary(bnd), .return_pc(rpc), .push_byte(seq[0]),
    .pop_byte(seq[1]), .call_push(seq[2]), .sub_return_instr(seq[3]),
    .irq_return_instr(iret_p), .io_addr(ia), .io_wr(iwr), .io_rd(ird), .io_wdata(iwd),
    .io_rdata(rdat), .core_reset(pr), .pc_load(pl), .pc_vector(vec), .push_ret(pret),
    .push_addr(paddr), .stack_pointer(sp), .global_en(gie), .ext0_flag(flag));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    ia <= a;
    iwd <= d;
    iwr <= 1'b1;
    @(posedge clk);
    iwr <= 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    ia <= a;
    ird <= 1'b1;
    @(posedge clk);
    ird <= 1'b0;
    @(negedge clk);
    chk({4'h0, rdat}, {4'h0, exp});
  endtask
  task entry(input logic [11:0] v);
    int n;
    n = 0;
    while (pret !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(vec, v);
    chk(paddr, rpc - 12'h001);
    chk({3'h0, gie, sp}, 12'h0ce);
  endtask
  task iret;
    @(posedge clk);
    iret_p <= 1'b1;
    @(posedge clk);
    iret_p <= 1'b0;
    @(negedge clk);
    chk({3'h0, gie, sp}, 12'h1d0);
  endtask
  task wait_core;
    int n;
    n = 0;
    while (pr !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk({11'h0, pr}, 12'h000);
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    {rst, pin_n, wdog, irq0, lvl, e1en, slow, iwr, ird, iret_p} = 10'h300;
    {src, seq, ia, iwd} = 30'h0;
    rise = 1'b1;
    pen = 9'h0ff;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    e1en <= 1'b1;
    wait_core;
    rd(6'h39, 8'h00);
    rd(6'h3a, 8'h00);
    wr(6'h3d, 8'hd0);
    rd(6'h3d, 8'hd0);
    wr(6'h39, 8'hff);
    rd(6'h39, 8'hca);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      seq <= 4'h1 << k;
      @(posedge clk);
      seq <= 4'h0;
      @(negedge clk);
      chk({4'h0, sp}, {4'h0, sp_tab[k]});
    end
    @(posedge clk);
    src <= 12'hfff;
    repeat (8) @(negedge clk);
    chk({4'h0, sp}, 12'h0d0);
    // sources stay pending so the synced ext_irq1 is ready when enabled
    wr(6'h3f, 8'h80);
    for (k = 2; k < 14; k++) begin
      @(posedge clk);
      src <= 12'hfff << (k - 2);
      entry(k[11:0]);
      @(posedge clk);
      src <= 12'h000;
      iret;
    end
    rd(6'h3f, 8'h80);
    @(posedge clk);
    pen <= 9'h000;
    src <= 12'hfe0;
    repeat (6) @(negedge clk);
    chk({3'h0, gie, sp}, 12'h1d0);
    @(posedge clk);
    pen <= 9'h0ff;
    src <= 12'h000;
    @(posedge clk);
    slow <= 1'b1;
    irq0 <= 1'b1;
    entry(12'h001);
    chk({11'h0, flag}, 12'h000);
    @(posedge clk);
    irq0 <= 1'b0;
    slow <= 1'b0;
    iret;
    wr(6'h3f, 8'h00);
    @(posedge clk);
    irq0 <= 1'b1;
    repeat (6) @(negedge clk);
    chk({11'h0, flag}, 12'h001);
    rd(6'h3a, 8'h40);
    wr(6'h3a, 8'h00);
    chk({11'h0, flag}, 12'h001);
    wr(6'h3a, 8'h40);
    chk({11'h0, flag}, 12'h000);
    @(posedge clk);
    lvl <= 1'b1;
    irq0 <= 1'b0;
    @(posedge clk);
    irq0 <= 1'b1;
    repeat (6) @(negedge clk);
    chk({11'h0, flag}, 12'h000);
    @(posedge clk);
    lvl <= 1'b0;
    rise <= 1'b0;
    @(posedge clk);
    irq0 <= 1'b0;
    repeat (6) @(negedge clk);
    chk({11'h0, flag}, 12'h001);
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      {wdog, pin_n} <= k ? 2'b00 : 2'b11;
      repeat (2) @(posedge clk);
      {wdog, pin_n} <= 2'b01;
      repeat (3) @(negedge clk);
      chk({pr, vec[10:0]}, 12'h800);
      wait_core;
    end
    complete_run;
  end
endmodule
`default_nettype wire

/* File: testbench/visu_core_props.sv */
// Purpose: port-level checks of the interrupt unit
// Assumes: one clock, async high reset
// Notes: bound to every visu_core
`timescale 1ns/1ps
`default_nettype none
module visu_props #(
  parameter TOUT_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // observed ports
  input wire logic core_reset,
  input wire logic pc_load,
  input wire logic [11:0] pc_vector,
  input wire logic push_ret,
  input wire logic [11:0] push_addr,
  input wire logic [11:0] return_pc,
  input wire logic [7:0] stack_pointer,
  input wire logic global_en,
  input wire logic ext0_flag,
  input wire logic ext0_level_mode,
  input wire logic io_wr,
  input wire logic push_byte,
  input wire logic pop_byte,
  input wire logic irq_return_instr
);
  // ==========
  // helper: cycles since reset release
  reg [15:0] up_cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cnt <= 16'h0000;
    end else if (up_cnt != 16'hffff) begin
      up_cnt <= up_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_entry;
    push_ret && pc_load;
  endsequence
  sequence s_level_held;
    ext0_level_mode [*2];
  endsequence
  a_entry_vector: assert property (
    s_entry |-> pc_vector >= 12'h001 && pc_vector <= 12'h00d) else $error("bad vector");
  a_entry_sp_dec: assert property (
    s_entry ##0 !$past(io_wr) |-> stack_pointer == $past(stack_pointer) - 8'h02)
    else $error("entry stack step");
  a_entry_gie_off: assert property (s_entry |-> !global_en)
    else $error("global enable kept");
  a_ret_addr: assert property (s_entry |-> push_addr == $past(return_pc))
    else $error("return address");
  a_flag_entry: assert property (s_entry ##0 pc_vector == 12'h001 |-> !ext0_flag)
    else $error("flag kept on entry");
  a_level_clear: assert property (s_level_held |-> !ext0_flag)
    else $error("flag in level mode");
  a_push_dec: assert property (
    push_byte && !pop_byte && !io_wr |=> push_ret || stack_pointer == $past(stack_pointer) - 8'h01)
    else $error("push step");
  a_ret_restore: assert property (
    irq_return_instr && !io_wr |=> global_en && stack_pointer == $past(stack_pointer) + 8'h02)
    else $error("return step");
  a_gie_gate: assert property (!global_en |=> !push_ret)
    else $error("entry while disabled");
  a_core_hold: assert property ($fell(core_reset) |-> up_cnt >= TOUT_CYCLES)
    else $error("core released early");
endmodule
bind visu_core visu_props #(.TOUT_CYCLES(TOUT_CYCLES)) i_props (.clk(clk), .rst(rst),
  .core_reset(core_reset), .pc_load(pc_load), .pc_vector(pc_vector), .push_ret(push_ret),
  .push_addr(push_addr), .return_pc(return_pc), .stack_pointer(stack_pointer),
  .global_en(global_en), .ext0_flag(ext0_flag), .ext0_level_mode(ext0_level_mode),
  .io_wr(io_wr), .push_byte(push_byte), .pop_byte(pop_byte),
  .irq_return_instr(irq_return_instr));
`default_nettype wire

/* File: testbench/visu_seq_model.sv */
// Purpose: core sequencer stand-in
// Assumes: shares clk with the unit
// Notes: slow mode offers a boundary one cycle in four
`timescale 1ns/1ps
`default_nettype none
module visu_seq_model (
  // clock and mode
  input wire logic clk,
  input wire logic slow,
  // to the unit
  output logic instr_boundary,
  output logic [11:0] return_pc
);
  initial return_pc = 12'h100;
  always @(posedge clk) begin
    return_pc <= return_pc + 12'h001;
  end
  // long instructions hold off acceptance
  assign instr_boundary = !slow || (return_pc[1:0] == 2'b00);
endmodule
`default_nettype wire
